// >>> rtl/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// register byte offsets
`define OFF_MODE 8'h00
`define OFF_CHAN 8'h04
`define OFF_FAIL 8'h08
`define OFF_THRESH 8'h0c
`define OFF_RESULT 8'h10
`define OFF_STATUS 8'h14
`define OFF_MASK 8'h18
// converter_mode_reg fields
`define MODE_ENABLE_BIT 7
`define MODE_REFPWR_BIT 6
`define MODE_SPEED_MSB 4
// channel_select_reg fields
`define CHAN_HWTRIG_BIT 7
`define CHAN_SEL_MSB 2
// fail_mode_reg fields
`define FAIL_EN_BIT 0
`define FAIL_BELOW_BIT 1
// conversion_irq_flag position in status and mask
`define IRQ_DONE_BIT 0
// reset values
`define RST_MODE 8'h00
`define RST_CHAN 8'h00
`define RST_FAIL 8'h00
`define RST_THRESH 8'h00
`endif

// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;
   // sequencer phases
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV} state_e;
   // per-setting durations in main-clock cycles
   typedef struct packed {
      logic [8:0] conv;
      logic [7:0] samp;
      logic [3:0] wr;
      logic [3:0] trg;
      logic ok;
   } timing_s;
endpackage

// >>> rtl/adc_conversion_sequencer.sv
// How it works
// RL1: result read finishes before new result stored
// RL2: mode/channel write beats completion; result dropped
// RL3: channel write leaves conversion flag untouched
// RL4: software clears flag before restarting conversions
// RL5: software discards first result after early enable
// RL6: software reads result before mode/channel writes
// RL7: no result reads on subclock, oscillator stopped
// RL8: no shared port reads during conversion
// RL9: sampling starts only after start delay
// RL10: speed/rate field sets conversion, sampling lengths
// RL11: write and trigger response delays per setting
// RL12: each completion stores result, raises interrupt; code sets the flag only when the power-fail compare passes
// RL13: config write aborts; software restarts, hardware waits
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input wire logic pclk, // bus clock, main clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [9:0] conv_code, // code from analog core at end
   input wire logic hw_trigger, // one-cycle hardware trigger
   output logic [2:0] chan_sel, // selected analog input
   output logic sample_en, // sample and hold switch on
   output logic ref_power, // reference ladder power
   output logic conversion_end_irq // level interrupt
);

   // speed/rate setting to durations; prohibited codes flagged not ok
   function automatic timing_s lookup(input logic [4:0] sel);
      timing_s t;
      t = '{9'h000, 8'h00, 4'h0, 4'h0, 1'b0};
      case (sel)
         5'h00: t = '{9'h120, 8'hb0, 4'hc, 4'h8, 1'b1};
         5'h01: t = '{9'h0f0, 8'hb0, 4'hc, 4'h8, 1'b1};
         5'h02: t = '{9'h0c0, 8'h84, 4'hb, 4'h7, 1'b1};
         5'h04: t = '{9'h090, 8'h58, 4'ha, 4'h6, 1'b1};
         5'h05: t = '{9'h078, 8'h58, 4'ha, 4'h6, 1'b1};
         5'h06: t = '{9'h060, 8'h30, 4'hc, 4'h8, 1'b1};
         5'h08: t = '{9'h060, 8'h30, 4'hc, 4'h8, 1'b1};
         5'h09: t = '{9'h048, 8'h24, 4'hb, 4'h7, 1'b1};
         5'h0a: t = '{9'h030, 8'h18, 4'ha, 4'h6, 1'b1};
         5'h0b: t = '{9'h018, 8'h0c, 4'h9, 4'h5, 1'b1};
         5'h0c: t = '{9'h0e0, 8'hb0, 4'hc, 4'h8, 1'b1};
         5'h0d: t = '{9'h0a8, 8'h84, 4'hb, 4'h7, 1'b1};
         5'h0e: t = '{9'h070, 8'h58, 4'ha, 4'h6, 1'b1};
         5'h0f: t = '{9'h038, 8'h2c, 4'h9, 4'h5, 1'b1};
         5'h10: t = '{9'h048, 8'h18, 4'hc, 4'h8, 1'b1};
         5'h11: t = '{9'h036, 8'h12, 4'hb, 4'h7, 1'b1};
         5'h12: t = '{9'h024, 8'h0c, 4'ha, 4'h6, 1'b1};
         5'h13: t = '{9'h012, 8'h06, 4'h9, 4'h5, 1'b1};
         default: t = '{9'h000, 8'h00, 4'h0, 4'h0, 1'b0};
      endcase
      return t;
   endfunction

   logic [7:0] mode_q, mode_d, chan_q, chan_d, fail_q, fail_d, thresh_q, thresh_d;
   logic [9:0] result_q, result_d, hold_q, hold_d;
   logic pend_q, pend_d;
   logic status_q, status_d, mask_q, mask_d, irq_q, irq_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   state_e state_q, state_d;
   logic [8:0] cnt_q, cnt_d;
   logic samp_q, samp_d;
   timing_s tim;
   logic acc, wr_en, rd_res, mapped, wr_mode, wr_chan, wr_cfg, fin, store, pass;
   logic [7:0] nmode, nchan;

   // access decode; writes land only at the edge where pready is high
   assign acc = psel & penable & pready_q;
   assign wr_en = acc & pwrite;
   assign rd_res = acc & ~pwrite & (paddr == `OFF_RESULT);
   assign wr_mode = wr_en & (paddr == `OFF_MODE);
   assign wr_chan = wr_en & (paddr == `OFF_CHAN);
   assign wr_cfg = wr_mode | wr_chan | (wr_en & (paddr == `OFF_FAIL))
                   | (wr_en & (paddr == `OFF_THRESH));
   assign nmode = wr_mode ? pwdata[7:0] : mode_q;
   assign nchan = wr_chan ? pwdata[7:0] : chan_q;
   assign tim = lookup(nmode[`MODE_SPEED_MSB:0]);
   assign fin = (state_q == ST_CONV) && (cnt_q == 9'h000);
   // only the high 8 bits take part in the power-fail comparison
   assign pass = !fail_q[`FAIL_EN_BIT]
                 || (fail_q[`FAIL_BELOW_BIT] ? (conv_code[9:2] < thresh_q)
                                             : (conv_code[9:2] >= thresh_q));
   assign store = fin && !(wr_mode | wr_chan); // [RL2]
   assign mapped = (paddr <= `OFF_MASK) && (paddr[1:0] == 2'b00);

   // apb: one wait state so read data leaves a flop
   always_comb
   begin
      pready_d = psel & penable & ~pready_q;
      pslverr_d = psel & penable & ~pready_q & ~mapped;
      prdata_d = prdata_q;
      if (psel & penable & ~pready_q & ~pwrite)
      begin
         case (paddr)
            `OFF_MODE: prdata_d = {24'h000000, mode_q};
            `OFF_CHAN: prdata_d = {24'h000000, chan_q};
            `OFF_FAIL: prdata_d = {30'h00000000, fail_q[1:0]};
            `OFF_THRESH: prdata_d = {24'h000000, thresh_q};
            `OFF_RESULT: prdata_d = {22'h000000, result_q};
            `OFF_STATUS: prdata_d = {31'h00000000, status_q};
            `OFF_MASK: prdata_d = {31'h00000000, mask_q};
            default: prdata_d = 32'h00000000;
         endcase
      end
   end

   // register file, result store and interrupt flag
   always_comb
   begin
      mode_d = nmode;
      chan_d = nchan;
      fail_d = (wr_en && paddr == `OFF_FAIL) ? {6'h00, pwdata[1:0]} : fail_q;
      thresh_d = (wr_en && paddr == `OFF_THRESH) ? pwdata[7:0] : thresh_q;
      mask_d = (wr_en && paddr == `OFF_MASK) ? pwdata[`IRQ_DONE_BIT] : mask_q;
      result_d = result_q;
      hold_d = hold_q;
      pend_d = 1'b0;
      if (pend_q)
         result_d = hold_q; // [RL1]
      if (store && rd_res)
      begin
         hold_d = conv_code; // read wins, write one cycle later [RL1]
         pend_d = 1'b1;
      end
      else if (store)
         result_d = conv_code; // [RL12]
      // channel writes never touch the flag; a set beats a clear
      status_d = status_q & ~(wr_en && paddr == `OFF_STATUS && pwdata[`IRQ_DONE_BIT]); // [RL3]
      if (store && pass)
         status_d = 1'b1; // [RL12]
      irq_d = status_d & mask_d;
   end

   // sequencer: start delay, sampling, conversion
   always_comb
   begin
      state_d = state_q;
      cnt_d = (cnt_q == 9'h000) ? 9'h000 : cnt_q - 9'h001;
      if (wr_cfg)
      begin
         // abort; software mode restarts, hardware mode waits [RL13]
         if (nmode[`MODE_ENABLE_BIT] && !nchan[`CHAN_HWTRIG_BIT] && tim.ok)
         begin
            state_d = ST_DELAY;
            cnt_d = {5'h00, tim.wr} - 9'h001; // [RL11]
         end
         else
            state_d = ST_IDLE;
      end
      else if (!mode_q[`MODE_ENABLE_BIT] || !tim.ok)
         state_d = ST_IDLE;
      else if (hw_trigger && chan_q[`CHAN_HWTRIG_BIT])
      begin
         state_d = ST_DELAY; // trigger restarts any conversion
         cnt_d = {5'h00, tim.trg} - 9'h001; // [RL11]
      end
      else
      begin
         case (state_q)
            ST_IDLE: state_d = ST_IDLE;
            ST_DELAY:
               if (cnt_q == 9'h000)
               begin
                  state_d = ST_SAMPLE; // [RL9]
                  cnt_d = {1'b0, tim.samp} - 9'h001; // [RL10]
               end
            ST_SAMPLE:
               if (cnt_q == 9'h000)
               begin
                  state_d = ST_CONV;
                  cnt_d = tim.conv - {1'b0, tim.samp} - 9'h001; // [RL10]
               end
            ST_CONV:
               if (cnt_q == 9'h000)
               begin
                  // software mode runs back to back
                  state_d = chan_q[`CHAN_HWTRIG_BIT] ? ST_IDLE : ST_SAMPLE;
                  cnt_d = {1'b0, tim.samp} - 9'h001;
               end
            default: state_d = ST_IDLE;
         endcase
      end
      samp_d = (state_d == ST_SAMPLE);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= `RST_MODE;
         chan_q <= `RST_CHAN;
         fail_q <= `RST_FAIL;
         thresh_q <= `RST_THRESH;
         result_q <= 10'h000;
         hold_q <= 10'h000;
         pend_q <= 1'b0;
         status_q <= 1'b0;
         mask_q <= 1'b0;
         irq_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         state_q <= ST_IDLE;
         cnt_q <= 9'h000;
         samp_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         chan_q <= chan_d;
         fail_q <= fail_d;
         thresh_q <= thresh_d;
         result_q <= result_d;
         hold_q <= hold_d;
         pend_q <= pend_d;
         status_q <= status_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         samp_q <= samp_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign chan_sel = chan_q[`CHAN_SEL_MSB:0];
   assign sample_en = samp_q;
   assign ref_power = mode_q[`MODE_REFPWR_BIT];
   assign conversion_end_irq = irq_q;

   // helper: cycles since sampling started, for length checks
   logic [8:0] run_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_q <= 9'h000;
      else if (state_q == ST_DELAY || state_q == ST_IDLE
               || (state_q == ST_CONV && state_d == ST_SAMPLE))
         run_q <= 9'h000;
      else
         run_q <= run_q + 9'h001;
   end

   localparam int WR_MAX = 13;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_read_first: assert property ((store && rd_res) |=> $stable(result_q) ##1 // [RL1]
      (result_q == $past(conv_code, 2))) else $error("read did not win over result store");
   a_write_wins: assert property ((fin && (wr_mode | wr_chan)) // [RL2]
      |=> $stable(result_q) && !$rose(status_q)) else $error("result stored despite config write");
   a_chan_keeps: assert property ((wr_chan && status_q && !(wr_en && paddr == `OFF_STATUS)) // [RL3]
      |=> status_q) else $error("channel write cleared flag");
   a_delay_first: assert property ($rose(sample_en) // [RL9]
      |-> $past(state_q) == ST_DELAY || $past(state_q) == ST_CONV)
      else $error("sampling without start delay");
   a_conv_len: assert property (fin |-> run_q + 9'h001 == tim.conv) // [RL10]
      else $error("conversion length wrong");
   a_samp_len: assert property ((state_q == ST_SAMPLE && state_d == ST_CONV && !wr_cfg) // [RL10]
      |-> run_q + 9'h001 == {1'b0, tim.samp}) else $error("sampling length wrong");
   a_wr_resp: assert property ((wr_mode && pwdata[`MODE_ENABLE_BIT] // [RL11]
      && !chan_q[`CHAN_HWTRIG_BIT] && tim.ok && !wr_chan)
      |-> ##[1:WR_MAX] (sample_en || state_q == ST_IDLE || wr_cfg))
      else $error("write response too slow");
   a_store_res: assert property ((store && !rd_res) |=> result_q == $past(conv_code)) // [RL12]
      else $error("result not stored");
   a_hw_abort: assert property ((wr_cfg && state_q != ST_IDLE && nchan[`CHAN_HWTRIG_BIT]) // [RL13]
      |=> state_q == ST_IDLE) else $error("hardware mode did not wait after abort");
   a_irq_level: assert property ((status_q && mask_q) [*2] |-> conversion_end_irq)
      else $error("interrupt not raised");

   c_normal_end: cover property (store && pass && !rd_res);
   c_read_clash: cover property (store && rd_res);
   c_write_clash: cover property (fin && (wr_mode | wr_chan));
   c_hw_restart: cover property (hw_trigger && chan_q[`CHAN_HWTRIG_BIT] && state_q == ST_CONV);
endmodule

// >>> verif/analog_core_model.sv
`timescale 1ns/1ps
module analog_core_model
(
   input wire logic pclk, // main clock
   input wire logic [2:0] chan_sel, // selected analog input
   input wire logic sample_en, // sample switch on
   output logic [9:0] conv_code // code handed to the sequencer
);
   logic [2:0] held_q = 3'h0;
   // the code marks the sampled channel, so a stale or wrong sample shows up
   always_ff @(posedge pclk)
   begin
      if (sample_en)
         held_q <= chan_sel;
   end
   // core only ever sees its analog input, never a shared port read
   assign conv_code = {held_q, 7'h55};
endmodule

// >>> verif/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer_tb;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_s;
   logic pclk, presetn, psel, penable, pwrite, hw_trigger, pready, pslverr, err;
   logic sample_en, ref_power, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] conv_code;
   logic [2:0] chan_sel;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   int k;
   // write value, expected read-back, expected error
   row_s rows [8] = '{
      '{`OFF_MODE, 32'h0000_0053, 32'h0000_0053, 1'b0},
      '{`OFF_CHAN, 32'hffff_ff83, 32'h0000_0083, 1'b0},
      '{`OFF_FAIL, 32'h0000_0003, 32'h0000_0003, 1'b0},
      '{`OFF_THRESH, 32'h0000_01ff, 32'h0000_00ff, 1'b0},
      '{`OFF_MASK, 32'h0000_0001, 32'h0000_0001, 1'b0},
      '{`OFF_RESULT, 32'h0000_03ff, 32'h0000_0000, 1'b0},
      '{8'h1c, 32'h0000_00aa, 32'h0000_0000, 1'b1},
      '{8'h02, 32'h0000_00aa, 32'h0000_0000, 1'b1}};

   adc_conversion_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_code(conv_code), .hw_trigger(hw_trigger),
      .chan_sel(chan_sel), .sample_en(sample_en), .ref_power(ref_power),
      .conversion_end_irq(irq));
   analog_core_model i_core (.pclk(pclk), .chan_sel(chan_sel), .sample_en(sample_en),
      .conv_code(conv_code));

   // free-running main clock, 100 ns
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // a hung handshake ends here rather than running forever
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         miscompares++;
         final_report;
      end
   end

   task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask

   // one apb transfer; entered just after an edge, one idle edge after release
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one-cycle trigger pulse, sampled at the edge where the task returns
   task trig;
      hw_trigger <= 1'b1;
      @(posedge pclk);
      hw_trigger <= 1'b0;
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      hw_trigger = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // every register reads zero after reset
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset_value", 32'h0, rd);
      end
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk("read_back", rows[i].r, rd);
         chk("slave_error", 32'(rows[i].e), 32'(err));
      end
      chk("ref_power", 32'h1, 32'(ref_power));
      chk("chan_sel", 32'h3, 32'(chan_sel));
      // hardware trigger mode, code 10011: enabling alone must not sample
      apb(1'b1, `OFF_FAIL, 32'h0);
      apb(1'b1, `OFF_THRESH, 32'h80);
      apb(1'b1, `OFF_MODE, 32'hd3);
      k = 0;
      repeat (20) @(posedge pclk) k += 32'(sample_en);
      chk("no_sample_before_trigger", 32'h0, k);
      trig();
      k = 0;
      do @(posedge pclk); while (sample_en !== 1'b1 && ++k < 40);
      // trigger response 4..5, one more allowed for the registered output
      chk("start_delay", 32'h1, 32'(k >= 4 && k <= 6));
      k = 0;
      while (sample_en === 1'b1)
      begin
         k++;
         @(posedge pclk);
      end
      chk("sample_cycles", 32'd6, k);
      k = 0;
      while (irq !== 1'b1 && k < 40)
      begin
         k++;
         @(posedge pclk);
      end
      chk("convert_cycles", 32'h1, 32'(k >= 12 && k <= 15));
      apb(1'b0, `OFF_RESULT, 32'h0);
      chk("result", 32'h1d5, rd);
      apb(1'b1, `OFF_CHAN, 32'h84);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("flag_kept", 32'h1, rd);
      apb(1'b1, `OFF_STATUS, 32'h1);
      @(posedge pclk);
      chk("irq_cleared", 32'h0, 32'(irq));
      // channel 4 gives 0x95 in the top bits: above 0x80 flags, below does not
      for (int f = 1; f <= 3; f += 2)
      begin
         apb(1'b1, `OFF_FAIL, 32'(f));
         trig();
         repeat (40) @(posedge pclk);
         apb(1'b0, `OFF_RESULT, 32'h0);
         chk("result_stored", 32'h255, rd);
         apb(1'b0, `OFF_STATUS, 32'h0);
         chk("compare_flag", 32'(f == 1), rd);
         apb(1'b1, `OFF_STATUS, 32'h1);
      end
      // a threshold write in the last sampling cycle aborts; hardware mode then waits
      trig();
      repeat (8) @(posedge pclk);
      apb(1'b1, `OFF_THRESH, 32'h80);
      repeat (40) @(posedge pclk);
      chk("abort_idle", 32'h0, 32'(sample_en));
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("abort_no_flag", 32'h0, rd);
      // masked flag keeps the line low until the mask opens
      apb(1'b1, `OFF_MASK, 32'h0);
      apb(1'b1, `OFF_FAIL, 32'h0);
      trig();
      repeat (40) @(posedge pclk);
      chk("masked_irq", 32'h0, 32'(irq));
      apb(1'b1, `OFF_MASK, 32'h1);
      @(posedge pclk);
      chk("unmasked_irq", 32'h1, 32'(irq));
      // software mode, reference off: flag left by the masked test is dropped, then first result polled for
      apb(1'b1, `OFF_MODE, 32'h93);
      apb(1'b1, `OFF_CHAN, 32'h05);
      for (int n = 0; n < 2; n++)
      begin
         rd = 32'h0;
         k = 0;
         while (rd[0] !== 1'b1 && ++k < 40)
            apb(1'b0, `OFF_STATUS, 32'h0);
         chk("sw_flag", 32'h1, rd);
         apb(1'b1, `OFF_STATUS, 32'h1);
      end
      // bench clock is always the main clock, so result reads are safe
      apb(1'b0, `OFF_RESULT, 32'h0);
      chk("sw_result", 32'h2d5, rd);
      apb(1'b1, `OFF_MODE, 32'h00);
      final_report;
   end
endmodule
